// ==== core/sspi_pkg.sv ====
// Purpose: shared constants, types and decode helpers for the sync serial port
// Assumes: 8-bit data held in 32-bit aligned APB words
// Notes:   byte offsets are APB byte addresses

package sspi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] SSPI_OFF_DATA = 8'h00;
  localparam logic [7:0] SSPI_OFF_STAT = 8'h04;
  localparam logic [7:0] SSPI_OFF_CTRL = 8'h08;
  localparam logic [7:0] SSPI_OFF_BAUD = 8'h0c;
  localparam logic [7:0] SSPI_OFF_EVT  = 8'h10;

  // reset values
  localparam logic [7:0] SSPI_RST_CTRL = 8'h00;
  localparam logic [7:0] SSPI_RST_BAUD = 8'h00;
  localparam logic [7:0] SSPI_RST_DATA = 8'h00;

  // field positions
  localparam int SSPI_STAT_SMP   = 7;
  localparam int SSPI_STAT_CKE   = 6;
  localparam int SSPI_EVT_PIF    = 0;
  localparam int SSPI_EVT_BCOL   = 1;
  localparam int SSPI_EVT_RSGO   = 4;
  localparam int SSPI_CTRL_WRITE_COLLISION_FLAG  = 7;
  localparam int SSPI_CTRL_OV    = 6;

  // mode field codes
  localparam logic [3:0] SSPI_M_SPI_F4  = 4'h0;
  localparam logic [3:0] SSPI_M_SPI_F16 = 4'h1;
  localparam logic [3:0] SSPI_M_SPI_F64 = 4'h2;
  localparam logic [3:0] SSPI_M_SPI_BRG = 4'h3;
  localparam logic [3:0] SSPI_M_SLV_SS  = 4'h4;
  localparam logic [3:0] SSPI_M_SLV     = 4'h5;
  localparam logic [3:0] SSPI_M_I2C_S10 = 4'h7;
  localparam logic [3:0] SSPI_M_I2C_HW  = 4'h8;
  localparam logic [3:0] SSPI_M_I2C_FW  = 4'hb;
  localparam logic [3:0] SSPI_M_I2C_S7P = 4'he;
  localparam logic [3:0] SSPI_M_I2C_S10P = 4'hf;

  // baud reload values (half period minus one, in system clocks)
  localparam logic [6:0] SSPI_DIV_F4  = 7'h01;
  localparam logic [6:0] SSPI_DIV_F16 = 7'h07;
  localparam logic [6:0] SSPI_DIV_F64 = 7'h1f;

  // transfer counts
  localparam logic [3:0] SSPI_LAST_BIT  = 4'h7;
  localparam logic [3:0] SSPI_LAST_EDGE = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       write_collision_flag;
    logic       ov;
    logic       en;
    logic       ckp;
    logic [3:0] mode;
  } sspi_ctl_t;

  typedef enum logic [2:0] {
    RS_IDLE,
    RS_SDA_REL,
    RS_SCL_REL,
    RS_HOLD,
    RS_SDA_LOW
  } sspi_rs_t;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic sspi_is_spi(input logic [3:0] m);
    return (m <= SSPI_M_SLV);
  endfunction

  function automatic logic sspi_is_spi_m(input logic [3:0] m);
    return (m <= SSPI_M_SPI_BRG);
  endfunction

  function automatic logic sspi_is_i2c_m(input logic [3:0] m);
    return (m == SSPI_M_I2C_HW) || (m == SSPI_M_I2C_FW);
  endfunction

  function automatic logic [6:0] sspi_div(input logic [3:0] m, input logic [6:0] baud_rate_generator);
    case (m)
      SSPI_M_SPI_F4:  return SSPI_DIV_F4;
      SSPI_M_SPI_F16: return SSPI_DIV_F16;
      SSPI_M_SPI_F64: return SSPI_DIV_F64;
      default:        return baud_rate_generator;
    endcase
  endfunction

endpackage

// ==== core/sspi_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to CLK
// Notes:   first stage is read only by the second

`timescale 1ns/1ps

module sspi_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= RST;
      q    <= RST;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // sspi_sync

// ==== core/sspi_baud.sv ====
// Purpose: reloadable down counter shared by spi clocking and i2c timing
// Assumes: load has priority over counting
// Notes:   zero is a level while the count rests at zero

`timescale 1ns/1ps

module sspi_baud #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              zero
);

  logic [W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= value;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign zero = (cnt == '0);

endmodule // sspi_baud

// ==== core/sspi_top.sv ====
// Purpose: sync serial port, spi data path and i2c repeated start master
// Assumes: apb slave on CLK_SYS, pins synchronised by two flops
// Notes:   i2c slave modes are decoded but have no engine here

`timescale 1ns/1ps

module sspi_top (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial clock pin (spi clock, i2c clock)
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE,
  // spi data pins
  input  wire logic        SDI,
  output logic             SDO,
  output logic             SDO_OE,
  input  wire logic        SS_N,
  // i2c data pin
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE,
  // pin ownership
  output logic             PINS_TO_PORT
);

  import sspi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  sspi_ctl_t  ctl;
  logic       smp;
  logic       cke;
  logic [7:0] baud;
  logic [7:0] rx_buf;
  logic [7:0] sr;
  logic       bf;
  logic       pif;
  logic       bcol;
  logic [3:0] bit_cnt;
  logic [3:0] edge_cnt;
  logic       m_run;
  logic       sck_d;
  logic       scl_low;
  logic       sda_low;
  sspi_rs_t   rs;
  sspi_rs_t   next_rs;
  logic       rs_load;
  logic       rs_col;
  logic [3:0] pin_s;
  logic       bz;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: sck, sdi, ss_n, sda
  sspi_sync #(
    .W   (4),
    .RST (4'hf)
  ) u_sync (
    .clk    (CLK_SYS),
    .resetn (RESETN),
    .d      ({SCK_I, SDI, SS_N, SDA_I}),
    .q      (pin_s)
  );

  wire sck_s  = pin_s[3];
  wire sdi_s  = pin_s[2];
  wire ss_n_s = pin_s[1];
  wire sda_s  = pin_s[0];
  wire scl_s  = pin_s[3];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire acc      = PSEL & PENABLE & PREADY;
  wire wr       = acc & PWRITE;
  wire rd       = acc & ~PWRITE;
  wire wr_data  = wr & (PADDR == SSPI_OFF_DATA);
  wire rd_data  = rd & (PADDR == SSPI_OFF_DATA);
  wire wr_stat  = wr & (PADDR == SSPI_OFF_STAT);
  wire wr_ctrl  = wr & (PADDR == SSPI_OFF_CTRL);
  wire wr_baud  = wr & (PADDR == SSPI_OFF_BAUD);
  wire wr_evt   = wr & (PADDR == SSPI_OFF_EVT);
  wire mapped   = (PADDR == SSPI_OFF_DATA) | (PADDR == SSPI_OFF_STAT)
                | (PADDR == SSPI_OFF_CTRL) | (PADDR == SSPI_OFF_BAUD)
                | (PADDR == SSPI_OFF_EVT);
  wire answer   = PSEL & PENABLE & ~PREADY;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  wire spi      = ctl.en & sspi_is_spi(ctl.mode);
  wire spi_m    = spi & sspi_is_spi_m(ctl.mode);
  wire spi_s    = spi & ~sspi_is_spi_m(ctl.mode);
  wire i2cm     = ctl.en & sspi_is_i2c_m(ctl.mode);
  // slave select only gates the slave when the ss mode is chosen
  wire ss_ok    = (ctl.mode != SSPI_M_SLV_SS) | ~ss_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // clock edges: master from its own divider, slave from the pin
  wire tick     = m_run & bz;
  wire m_lead   = tick & (SCK_O == ctl.ckp);
  wire s_edge   = spi_s & ss_ok & (sck_s != sck_d);
  wire s_lead   = s_edge & (sck_d == ctl.ckp);
  wire lead     = m_lead | s_lead;
  wire trail    = (tick | s_edge) & ~lead;
  wire in_edge  = cke ? lead : trail;
  wire out_edge = cke ? trail : lead;
  // late sampling only makes sense in master with output on trailing edge
  wire samp     = (smp & spi_m & cke) ? trail : in_edge;

  wire [7:0] rx_byte = {sr[6:0], sdi_s};
  wire done     = samp & (bit_cnt == SSPI_LAST_BIT);
  wire busy     = m_run | (bit_cnt != '0) | (rs != RS_IDLE);
  wire wr_ok    = wr_data & ~busy;
  wire wr_col   = wr_data & busy;
  wire rs_go    = wr_evt & PWDATA[SSPI_EVT_RSGO] & i2cm & ~busy;

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: spi half period or i2c repeated start timing
  wire       b_load  = (wr_ok & spi_m) | tick | rs_load;
  wire [6:0] b_value = spi_m ? sspi_div(ctl.mode, baud[6:0]) : baud[6:0];

  sspi_baud #(
    .W (7)
  ) u_baud (
    .clk    (CLK_SYS),
    .resetn (RESETN),
    .load   (b_load),
    .value  (b_value),
    .zero   (bz)
  );

  ////////////////////////////////////////////////////////////////////////////
  // repeated start sequencer
  always_comb begin
    next_rs = rs;
    rs_load = 1'b0;
    rs_col  = 1'b0;
    case (rs)
      RS_IDLE: begin
        if (rs_go) begin
          next_rs = RS_SDA_REL;
          rs_load = 1'b1;
        end
      end
      RS_SDA_REL: begin
        if (bz) next_rs = RS_SCL_REL;
      end
      RS_SCL_REL: begin
        if (scl_s) begin
          if (!sda_s) begin
            rs_col = 1'b1;
          end else begin
            next_rs = RS_HOLD;
            rs_load = 1'b1;
          end
        end
      end
      RS_HOLD: begin
        // sda pulled low by another master here is not a collision
        if (!scl_s && sda_s) begin
          rs_col = 1'b1;
        end else if (bz) begin
          next_rs = RS_SDA_LOW;
          rs_load = 1'b1;
        end
      end
      RS_SDA_LOW: begin
        if (bz) next_rs = RS_IDLE;
      end
      default: next_rs = RS_IDLE;
    endcase
    if (rs_col || !i2cm) next_rs = RS_IDLE;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) rs <= RS_IDLE;
    else         rs <= next_rs;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN || !i2cm || rs_col) begin
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      if (rs_go) scl_low <= 1'b1;
      else if (rs == RS_SDA_REL && bz) scl_low <= 1'b0;
      else if (rs == RS_SDA_LOW && bz) scl_low <= 1'b1;
      if (rs_go) sda_low <= 1'b0;
      else if (rs == RS_HOLD && next_rs == RS_SDA_LOW) sda_low <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ctl  <= SSPI_RST_CTRL;
      baud <= SSPI_RST_BAUD;
      smp  <= 1'b0;
      cke  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctl.en   <= PWDATA[5];
        ctl.ckp  <= PWDATA[4];
        ctl.mode <= PWDATA[3:0];
      end
      // set wins over a clearing write
      ctl.write_collision_flag <= wr_col | (ctl.write_collision_flag & ~(wr_ctrl & ~PWDATA[SSPI_CTRL_WRITE_COLLISION_FLAG]));
      ctl.ov   <= (done & bf) | (ctl.ov & ~(wr_ctrl & ~PWDATA[SSPI_CTRL_OV]));
      if (wr_baud) baud <= PWDATA[7:0];
      if (wr_stat) begin
        smp <= PWDATA[SSPI_STAT_SMP];
        cke <= PWDATA[SSPI_STAT_CKE];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      pif  <= 1'b0;
      bcol <= 1'b0;
    end else begin
      pif  <= done | rs_col | (pif & ~(wr_evt & ~PWDATA[SSPI_EVT_PIF]));
      bcol <= rs_col | (bcol & ~(wr_evt & ~PWDATA[SSPI_EVT_BCOL]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer; an overflowing byte never overwrites unread data
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rx_buf <= SSPI_RST_DATA;
      bf     <= 1'b0;
    end else begin
      if (done && !bf) rx_buf <= rx_byte;
      bf <= done | (bf & ~rd_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift engine
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      sr       <= SSPI_RST_DATA;
      bit_cnt  <= '0;
      edge_cnt <= '0;
      m_run    <= 1'b0;
      // matches the synchroniser's reset level so no false edge follows reset
      sck_d    <= 1'b1;
    end else begin
      sck_d <= sck_s;
      if (wr_ok) sr <= PWDATA[7:0];
      else if (samp) sr <= rx_byte;
      if (!spi || (spi_s && !ss_ok)) bit_cnt <= '0;
      else if (samp) bit_cnt <= done ? 4'h0 : bit_cnt + 4'h1;
      if (wr_ok && spi_m) edge_cnt <= '0;
      else if (tick) edge_cnt <= edge_cnt + 4'h1;
      if (!spi_m) m_run <= 1'b0;
      else if (wr_ok) m_run <= 1'b1;
      else if (tick && edge_cnt == SSPI_LAST_EDGE) m_run <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; all released while the port is disabled
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      SCK_O        <= 1'b0;
      SCK_OE       <= 1'b0;
      SDO          <= 1'b0;
      SDO_OE       <= 1'b0;
      SDA_O        <= 1'b0;
      SDA_OE       <= 1'b0;
      PINS_TO_PORT <= 1'b0;
    end else begin
      if (!m_run) SCK_O <= spi_m ? ctl.ckp : 1'b0;
      else if (tick) SCK_O <= ~SCK_O;
      SCK_OE <= spi_m | (i2cm & scl_low);
      if (wr_ok && cke) SDO <= PWDATA[7];
      else if (out_edge) SDO <= samp ? sr[6] : sr[7];
      SDO_OE <= spi & ss_ok;
      SDA_O  <= 1'b0;
      SDA_OE <= i2cm & sda_low;
      PINS_TO_PORT <= ctl.en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, so reads see settled state
  wire [31:0] rd_mux =
      (PADDR == SSPI_OFF_DATA) ? {24'h000000, rx_buf} :
      (PADDR == SSPI_OFF_STAT) ? {24'h000000, smp, cke, 3'b000, busy, 1'b0, bf} :
      (PADDR == SSPI_OFF_CTRL) ? {24'h000000, ctl} :
      (PADDR == SSPI_OFF_BAUD) ? {24'h000000, baud} :
      (PADDR == SSPI_OFF_EVT)  ? {29'h00000000, rs != RS_IDLE, bcol, pif} :
                                 32'h00000000;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= answer;
      PSLVERR <= answer & ~mapped;
      if (answer && !PWRITE) PRDATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  chk_done_sets_full: assert property (done |=> bf && pif)
    else $error("completed byte did not set full and interrupt");

  chk_rx_load_byte: assert property (done && !bf |=> rx_buf == $past(rx_byte))
    else $error("received byte not moved to buffer");

  chk_write_collision_flag_on_busy: assert property (wr_data && busy |=> ctl.write_collision_flag && (sr == $past(sr, 1)
                                     || $past(samp)))
    else $error("busy buffer write not flagged or not dropped");

  chk_write_collision_flag_sticky: assert property (ctl.write_collision_flag && !wr_ctrl |=> ctl.write_collision_flag)
    else $error("write collision flag dropped without software");

  chk_read_clears_bf: assert property (rd_data && !done |=> !bf)
    else $error("buffer read did not clear full flag");

  chk_overflow_set: assert property (done && bf |=> ctl.ov && rx_buf == $past(rx_buf))
    else $error("overflow not flagged or buffer overwritten");

  chk_disable_pins: assert property (!ctl.en |=> !SCK_OE && !SDO_OE && !SDA_OE && !PINS_TO_PORT)
    else $error("pins still driven while port disabled");

  chk_master_clock: assert property (spi_m |=> SCK_OE)
    else $error("spi master not driving clock");

  chk_first_msb: assert property (wr_ok && cke |=> SDO == $past(PWDATA[7]))
    else $error("first data bit is not msb");

  chk_col_release: assert property (rs_col |=> bcol && rs == RS_IDLE ##1 !SDA_OE && !SCK_OE)
    else $error("collision did not abort and release pins");

  chk_rs_sda_early: assert property (rs == RS_SCL_REL && scl_s && !sda_s
                                     |=> bcol && pif && rs == RS_IDLE)
    else $error("sda low at scl rise not seen as collision");

endmodule // sspi_top

// ==== tb/sspi_peer.sv ====
// Purpose: far side of the port: spi slave on the clock pin, i2c peer on scl and sda
// Assumes: spi clock idles low, data captured on rising and changed on falling edges
// Notes:   a kick pulls scl low shortly after it rises, as a rival master would

`timescale 1ns/1ps

module sspi_peer (
  // system clock
  input  wire logic       clk,
  // spi side
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic [7:0] tx,
  output logic            sdi,
  output logic [7:0]      rx,
  // i2c side
  input  wire logic       scl,
  input  wire logic       hold_sda,
  input  wire logic       kick_scl,
  output logic            sda_low,
  output logic            scl_low
);
  logic [2:0] idx   = 3'h7;
  logic       sck_d = 1'b0;
  logic       scl_d = 1'b1;
  logic [4:0] kick  = 5'h00;

  // the slave always shows its current bit, so the first bit is ready before any edge
  assign sdi     = tx[idx];
  assign sda_low = hold_sda;
  assign scl_low = (kick != 5'h00) && (kick < 5'h12);

  always @(posedge clk) begin
    sck_d <= sck;
    scl_d <= scl;
    if (sck && !sck_d) begin
      rx <= {rx[6:0], sdo};
    end
    if (!sck && sck_d) begin
      idx <= idx - 3'h1;
    end
    if (kick_scl && scl && !scl_d) begin
      kick <= 5'h14;
    end else if (kick != 5'h00) begin
      kick <= kick - 5'h01;
    end
  end
endmodule // sspi_peer

// ==== tb/test_sync_serial_port_spi_i2c.sv ====
// Purpose: self-checking bench for the sync serial port over apb
// Assumes: read notes are queued by the driver and compared by the monitor
// Notes:   slave select is tied inactive, slave modes are only decoded

`timescale 1ns/1ps

module test_sync_serial_port_spi_i2c;
  import sspi_pkg::*;

  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    logic        err;
  } sspi_note_t;

  logic        CLK_SYS, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd_v;
  logic        PREADY, PSLVERR, SCK_O, SCK_OE, SDI, SDO, SDO_OE, SDA_O, SDA_OE, PINS_TO_PORT;
  logic        SS_N = 1'b1, hold = 1'b0, kick = 1'b0, sda_low, scl_low;
  wire  logic  sck_w, sda_w, spi_sck;
  logic [7:0]  peer_tx = 8'h00, peer_rx, a, b, t1;
  int          miscompares = 0, checked = 0, c;
  sspi_note_t  notes[$], cur;
  logic [3:0]  modes [11] = '{SSPI_M_SPI_F4, SSPI_M_SPI_F16, SSPI_M_SPI_F64, SSPI_M_SPI_BRG,
    SSPI_M_SLV_SS, SSPI_M_SLV, SSPI_M_I2C_S10, SSPI_M_I2C_HW, SSPI_M_I2C_FW,
    SSPI_M_I2C_S7P, SSPI_M_I2C_S10P};

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // pull-ups on both i2c lines; the clock pin is push-pull in spi master mode
  assign sck_w = SCK_OE ? SCK_O : ~scl_low;
  assign sda_w = ~(SDA_OE | sda_low);
  // the spi slave only sees the clock while the master drives it, so enabling
  // the port (pull-up level dropping to idle) is not taken as a shift edge
  assign spi_sck = SCK_OE & SCK_O;

  sspi_top dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCK_I(sck_w), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SDI(SDI),
    .SDO(SDO), .SDO_OE(SDO_OE), .SS_N(SS_N), .SDA_I(sda_w), .SDA_O(SDA_O),
    .SDA_OE(SDA_OE), .PINS_TO_PORT(PINS_TO_PORT));

  sspi_peer peer (.clk(CLK_SYS), .sck(spi_sck), .sdo(SDO), .tx(peer_tx), .sdi(SDI),
    .rx(peer_rx), .scl(sck_w), .hold_sda(hold), .kick_scl(kick), .sda_low(sda_low),
    .scl_low(scl_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic flag(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    // the request stands until the rising edge at which ready is sampled high
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      flag("pready", 32'h1, 32'h0);
      close_out();
    end
    rd_v = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    notes.push_back('{exp: e, msk: m, err: er});
    apb(1'b0, ad, 32'h0);
  endtask

  task automatic poll(input logic [7:0] ad, input int bt, input logic v);
    int n;
    n = 0;
    do begin
      rd(ad, 32'h0, 32'h0, 1'b0);
      n++;
    end while (rd_v[bt] !== v && n < 300);
    if (n >= 300) begin
      flag("poll", {31'h0, v}, {31'h0, rd_v[bt]});
      close_out();
    end
  endtask

  always @(posedge CLK_SYS) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && notes.size() > 0) begin
      cur = notes.pop_front();
      flag("prdata", cur.exp & cur.msk, PRDATA & cur.msk);
      flag("pslverr", {31'h0, cur.err}, {31'h0, PSLVERR});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    c = $urandom(32'h97034a3a);
    repeat (20) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(SSPI_OFF_CTRL, {24'h0, SSPI_RST_CTRL}, 32'hffffffff, 1'b0);
    rd(SSPI_OFF_BAUD, {24'h0, SSPI_RST_BAUD}, 32'hffffffff, 1'b0);
    rd(SSPI_OFF_STAT, 32'h0, 32'hffffffff, 1'b0);
    rd(8'h14, 32'h0, 32'hffffffff, 1'b1);
    foreach (modes[i]) begin
      a = {3'h0, 1'($urandom), modes[i]};
      wr(SSPI_OFF_CTRL, a);
      rd(SSPI_OFF_CTRL, {24'h0, a}, 32'hffffffff, 1'b0);
    end
    wr(SSPI_OFF_STAT, 8'hc0);
    rd(SSPI_OFF_STAT, 32'hc0, 32'hffffffff, 1'b0);
    flag("pins", 32'h0, {31'h0, PINS_TO_PORT});
    $display("test registers done");

    wr(SSPI_OFF_BAUD, 8'h07);
    wr(SSPI_OFF_STAT, 8'h40);
    wr(SSPI_OFF_CTRL, 8'h23);
    // pin controls follow the control register one clock after the write lands
    repeat (2) @(negedge CLK_SYS);
    flag("pins", 32'h1, {31'h0, PINS_TO_PORT});
    flag("sck_oe", 32'h1, {31'h0, SCK_OE});
    flag("sdo_oe", 32'h1, {31'h0, SDO_OE});
    a = 8'($urandom);
    b = ~a;
    t1 = 8'($urandom);
    peer_tx <= t1;
    wr(SSPI_OFF_DATA, a);
    wr(SSPI_OFF_DATA, b);
    poll(SSPI_OFF_STAT, 0, 1'b1);
    rd(SSPI_OFF_EVT, 32'h1, 32'h1, 1'b0);
    rd(SSPI_OFF_DATA, {24'h0, t1}, 32'hffffffff, 1'b0);
    flag("peer_rx", {24'h0, a}, {24'h0, peer_rx});
    rd(SSPI_OFF_STAT, 32'h40, 32'hffffffff, 1'b0);
    rd(SSPI_OFF_CTRL, 32'ha3, 32'hffffffff, 1'b0);
    wr(SSPI_OFF_CTRL, 8'h23);
    rd(SSPI_OFF_CTRL, 32'h23, 32'hffffffff, 1'b0);
    $display("test spi transfer done");

    t1 = 8'($urandom);
    peer_tx <= t1;
    wr(SSPI_OFF_DATA, a);
    poll(SSPI_OFF_STAT, 0, 1'b1);
    // the last trailing clock edge still counts as busy; wait it out
    poll(SSPI_OFF_STAT, 2, 1'b0);
    peer_tx <= ~t1;
    wr(SSPI_OFF_DATA, b);
    poll(SSPI_OFF_CTRL, 6, 1'b1);
    flag("peer_rx", {24'h0, b}, {24'h0, peer_rx});
    rd(SSPI_OFF_DATA, {24'h0, t1}, 32'hffffffff, 1'b0);
    rd(SSPI_OFF_CTRL, 32'h63, 32'hffffffff, 1'b0);
    wr(SSPI_OFF_CTRL, 8'h03);
    rd(SSPI_OFF_CTRL, 32'h03, 32'hffffffff, 1'b0);
    flag("pins", 32'h0, {31'h0, PINS_TO_PORT});
    $display("test overflow done");

    wr(SSPI_OFF_BAUD, 8'h04);
    wr(SSPI_OFF_CTRL, 8'h28);
    for (c = 0; c < 3; c++) begin
      hold <= (c == 1);
      kick <= (c == 2);
      wr(SSPI_OFF_EVT, 8'h00);
      wr(SSPI_OFF_EVT, 8'h10);
      if (c == 0) begin
        wr(SSPI_OFF_DATA, a);
      end
      poll(SSPI_OFF_EVT, 2, 1'b0);
      if (c == 0) begin
        rd(SSPI_OFF_EVT, 32'h0, 32'h2, 1'b0);
        flag("sda_oe", 32'h1, {31'h0, SDA_OE});
        flag("sck_oe", 32'h1, {31'h0, SCK_OE});
        flag("sda_o", 32'h0, {31'h0, SDA_O});
        rd(SSPI_OFF_CTRL, 32'h80, 32'h80, 1'b0);
        wr(SSPI_OFF_CTRL, 8'h28);
      end else begin
        rd(SSPI_OFF_EVT, 32'h3, 32'h3, 1'b0);
        flag("sda_oe", 32'h0, {31'h0, SDA_OE});
        flag("sck_oe", 32'h0, {31'h0, SCK_OE});
      end
    end
    hold <= 1'b0;
    kick <= 1'b0;
    $display("test repeated start done");
    close_out();
  end
endmodule // test_sync_serial_port_spi_i2c
